// [pgcs_defs.svh]
// register offsets, field positions, reset values of the synthesizer regs
//
// Contract
// [RULE1] select 1010 drives quantizer low bits out
// [RULE2] select zero drives static data bits 6:4
// [RULE3] bit 7 enables output pad drivers
// [RULE4] bits 10:8 disable individual pad drivers
// [RULE5] slip step count; zero disables prevention
// [RULE6] step low bit gives direction; release gates
// [RULE7] override bit 4 picks manual or auto reset
// [RULE8] override reset tri-states charge pump
// [RULE9] release bit 5 resets one; needs reg1 bit 15
// [RULE10] status bit 0 reads lock state
// [RULE11] status bits 3:1 report modulator overflow
// [RULE12] status bit 5 set while sweep runs
// [RULE13] temperature code floor((t+40)/17.5), saturating
// [RULE14] select field bits 3:0 choose output set
// [RULE15] read-only and reserved writes ignored
`ifndef PGCS_DEFS_SVH
`define PGCS_DEFS_SVH

// ==========================================================
// offsets
`define PGCS_OFS_GEN_OUT_CTRL 8'h1B
`define PGCS_OFS_CSP_CTRL 8'h1C
`define PGCS_OFS_RSVD_A 8'h1D
`define PGCS_OFS_TSENS_CTRL 8'h1E
`define PGCS_OFS_STATUS 8'h1F
`define PGCS_OFS_RSVD_B 8'h20
`define PGCS_OFS_TEMP_READ 8'h21
`define PGCS_OFS_RSVD_C 8'h22

// ==========================================================
// field positions
`define PGCS_GO_SEL_HI 3
`define PGCS_GO_SEL_LO 0
`define PGCS_GO_DATA_HI 6
`define PGCS_GO_DATA_LO 4
`define PGCS_GO_DRIVE_EN 7
`define PGCS_GO_DIS_HI 10
`define PGCS_GO_DIS_LO 8
`define PGCS_CSP_STEP_HI 3
`define PGCS_CSP_STEP_LO 0
`define PGCS_CSP_FORCE 4
`define PGCS_CSP_RELEASE 5
`define PGCS_TS_ENABLE 0

// ==========================================================
// select codes and reset values
`define PGCS_SEL_STATIC 4'h0
`define PGCS_SEL_SWEEP 4'h8
`define PGCS_SEL_QUANT 4'hA
`define PGCS_RST_GEN_OUT 11'h000
`define PGCS_RST_STEP 4'h0
`define PGCS_RST_FORCE 1'h0
`define PGCS_RST_RELEASE 1'h1
`define PGCS_RST_TS_EN 1'h0
`define PGCS_RST_RSVD_A 24'h000000
`define PGCS_RST_RSVD_B 24'h000020
`define PGCS_RST_RSVD_C 24'h000000
`define PGCS_RST_TEMP 7'h1F
`define PGCS_TEMP_MAX 7'h07

`endif

// [pgcs_pkg.sv]
// types of the synthesizer control and status register group
package pgcs_pkg;

	typedef struct packed {
		logic [10:0] gen_out_ctrl;
		logic [3:0] step;
		logic force_rst;
		logic release_rst;
		logic ts_en;
		logic [5:0] stat_s1;
		logic [5:0] stat_s2;
		logic [5:0] stat_s3;
		logic [5:0] stat;
		logic [7:0] temp_s1;
		logic [7:0] temp_s2;
		logic [7:0] temp_s3;
		logic [6:0] temp_code;
		logic [2:0] gpo;
		logic [2:0] gpo_oe;
		logic [3:0] slip_step_count;
		logic slip_direction;
		logic slip_enable;
		logic pfd_ff_reset_n;
		logic charge_pump_tristate;
		logic [23:0] rdata;
		logic rvalid;
	} pgcs_state_type;

endpackage

// [pgcs_regs.sv]
// control and status registers for outputs, slip prevention and status
`include "pgcs_defs.svh"

module pgcs_regs
	import pgcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	// register port from the serial port decoder
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	output logic reg_rvalid,
	// internal sources, same clock
	input wire logic [2:0] dsm_quant,
	input wire logic pfd_gain_enable,
	input wire logic csp_auto_reset_n,
	// status pins from analog and other domains
	input wire logic locked_in,
	input wire logic [2:0] modulator_overflow_in,
	input wire logic sweep_active_in,
	input wire logic signed [7:0] temp_celsius,
	// general purpose output pads
	output logic general_output_one,
	output logic general_output_two,
	output logic general_output_three,
	output logic general_output_one_oe,
	output logic general_output_two_oe,
	output logic general_output_three_oe,
	// cycle slip prevention controls
	output logic [3:0] slip_step_count,
	output logic slip_direction,
	output logic cycle_slip_prevention,
	output logic pfd_ff_reset_n,
	output logic charge_pump_tristate
);

	// ==========================================================
	// helpers

	// 17.5 degree steps: floor(2*(t+40)/35), clamped to 0..7
	function automatic logic [6:0] temp_to_code(
		input logic signed [7:0] t
	);
		logic signed [10:0] twice;
		logic [6:0] code;
		twice = 11'(2 * (11'(t) + 11'sd40));
		code = 7'h00;
		if (twice < 11'sd0) begin
			code = 7'h00;
		end else if (twice >= 11'sd245) begin
			code = `PGCS_TEMP_MAX; // [RULE13]
		end else begin
			code = 7'(twice / 11'sd35); // [RULE13]
		end
		return code;
	endfunction

	// a pin change is accepted once stages two and three agree
	function automatic logic [7:0] settle(
		input logic [7:0] held,
		input logic [7:0] s2,
		input logic [7:0] s3
	);
		logic [7:0] r;
		r = held;
		for (int i = 0; i < 8; i++) begin
			if (s2[i] == s3[i]) begin
				r[i] = s3[i];
			end
		end
		return r;
	endfunction

	pgcs_state_type q, d;

	// ==========================================================
	// next state
	always_comb begin
		logic [3:0] sel;
		logic [2:0] static_data;
		logic [2:0] dis;
		logic [2:0] gpo_v;
		logic [7:0] st_wide;
		logic gate_ok;
		sel = 4'h0;
		static_data = 3'h0;
		dis = 3'h0;
		gpo_v = 3'h0;
		st_wide = 8'h00;
		gate_ok = 1'b0;
		d = q;

		// register writes; read-only and reserved offsets fall through
		if (reg_wr) begin
			if (reg_addr == `PGCS_OFS_GEN_OUT_CTRL) begin
				d.gen_out_ctrl = reg_wdata[`PGCS_GO_DIS_HI:0];
			end else if (reg_addr == `PGCS_OFS_CSP_CTRL) begin
				d.step = reg_wdata[`PGCS_CSP_STEP_HI:`PGCS_CSP_STEP_LO];
				d.force_rst = reg_wdata[`PGCS_CSP_FORCE];
				d.release_rst = reg_wdata[`PGCS_CSP_RELEASE];
			end else if (reg_addr == `PGCS_OFS_TSENS_CTRL) begin
				d.ts_en = reg_wdata[`PGCS_TS_ENABLE];
			end
		end // [RULE15]

		// status pin synchronisers
		d.stat_s1 = {sweep_active_in, 1'b0, modulator_overflow_in,
			locked_in};
		d.stat_s2 = q.stat_s1;
		d.stat_s3 = q.stat_s2;
		st_wide = settle({2'b00, q.stat}, {2'b00, q.stat_s2},
			{2'b00, q.stat_s3});
		d.stat = st_wide[5:0]; // [RULE10] [RULE11] [RULE12]
		d.temp_s1 = temp_celsius;
		d.temp_s2 = q.temp_s1;
		d.temp_s3 = q.temp_s2;
		// whole word must agree so a code is never a mix of two samples
		if (q.ts_en && q.temp_s2 == q.temp_s3) begin
			d.temp_code = temp_to_code(q.temp_s3); // [RULE13]
		end

		// general purpose outputs
		sel = q.gen_out_ctrl[`PGCS_GO_SEL_HI:`PGCS_GO_SEL_LO];
		static_data = q.gen_out_ctrl[`PGCS_GO_DATA_HI:`PGCS_GO_DATA_LO];
		dis = q.gen_out_ctrl[`PGCS_GO_DIS_HI:`PGCS_GO_DIS_LO];
		gpo_v = 3'h0;
		case (sel) // [RULE14]
			`PGCS_SEL_STATIC: begin
				gpo_v = static_data; // [RULE2]
			end
			`PGCS_SEL_SWEEP: begin
				gpo_v = {1'b0, q.stat[5], 1'b0};
			end
			`PGCS_SEL_QUANT: begin
				gpo_v = dsm_quant; // [RULE1]
			end
			default: begin
				gpo_v = 3'h0;
			end
		endcase
		d.gpo = gpo_v;
		for (int i = 0; i < 3; i++) begin
			d.gpo_oe[i] = q.gen_out_ctrl[`PGCS_GO_DRIVE_EN] // [RULE3]
				& ~dis[i]; // [RULE4]
		end

		// cycle slip prevention
		gate_ok = q.release_rst & pfd_gain_enable; // [RULE9]
		d.slip_step_count = q.step; // [RULE5]
		d.slip_direction = q.step[0]; // [RULE6]
		d.slip_enable = (q.step != 4'h0) & gate_ok; // [RULE5] [RULE6]
		if (q.force_rst) begin
			d.pfd_ff_reset_n = q.release_rst; // [RULE7]
		end else begin
			d.pfd_ff_reset_n = csp_auto_reset_n; // [RULE7]
		end
		// a held reset opens the loop; default override is off
		d.charge_pump_tristate = q.force_rst & ~q.release_rst; // [RULE8]

		// read answer one cycle after the strobe
		d.rvalid = reg_rd;
		if (reg_rd) begin
			if (reg_addr == `PGCS_OFS_GEN_OUT_CTRL) begin
				d.rdata = {13'h0000, q.gen_out_ctrl};
			end else if (reg_addr == `PGCS_OFS_CSP_CTRL) begin
				d.rdata = {18'h00000, q.release_rst, q.force_rst, q.step};
			end else if (reg_addr == `PGCS_OFS_RSVD_A) begin
				d.rdata = `PGCS_RST_RSVD_A; // [RULE15]
			end else if (reg_addr == `PGCS_OFS_TSENS_CTRL) begin
				d.rdata = {23'h000000, q.ts_en};
			end else if (reg_addr == `PGCS_OFS_STATUS) begin
				d.rdata = {18'h00000, q.stat}; // [RULE10] [RULE12]
			end else if (reg_addr == `PGCS_OFS_RSVD_B) begin
				d.rdata = `PGCS_RST_RSVD_B; // [RULE15]
			end else if (reg_addr == `PGCS_OFS_TEMP_READ) begin
				d.rdata = {17'h00000, q.temp_code};
			end else if (reg_addr == `PGCS_OFS_RSVD_C) begin
				d.rdata = `PGCS_RST_RSVD_C; // [RULE15]
			end else begin
				d.rdata = 24'h000000;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q.gen_out_ctrl <= `PGCS_RST_GEN_OUT;
			q.step <= `PGCS_RST_STEP;
			q.force_rst <= `PGCS_RST_FORCE;
			q.release_rst <= `PGCS_RST_RELEASE; // [RULE9]
			q.ts_en <= `PGCS_RST_TS_EN;
			q.stat_s1 <= 6'h00;
			q.stat_s2 <= 6'h00;
			q.stat_s3 <= 6'h00;
			q.stat <= 6'h00; // [RULE11]
			q.temp_s1 <= 8'h00;
			q.temp_s2 <= 8'h00;
			q.temp_s3 <= 8'h00;
			q.temp_code <= `PGCS_RST_TEMP;
			q.gpo <= 3'h0;
			q.gpo_oe <= 3'h0;
			q.slip_step_count <= 4'h0;
			q.slip_direction <= 1'b0;
			q.slip_enable <= 1'b0;
			q.pfd_ff_reset_n <= 1'b0;
			q.charge_pump_tristate <= 1'b0;
			q.rdata <= 24'h000000;
			q.rvalid <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs, all straight from flops
	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	assign general_output_one = q.gpo[0];
	assign general_output_two = q.gpo[1];
	assign general_output_three = q.gpo[2];
	assign general_output_one_oe = q.gpo_oe[0];
	assign general_output_two_oe = q.gpo_oe[1];
	assign general_output_three_oe = q.gpo_oe[2];
	assign slip_step_count = q.slip_step_count;
	assign slip_direction = q.slip_direction;
	assign cycle_slip_prevention = q.slip_enable;
	assign pfd_ff_reset_n = q.pfd_ff_reset_n;
	assign charge_pump_tristate = q.charge_pump_tristate;

endmodule

// [pgcs_monitor.sv]
// concurrent checks on the synthesizer register group ports
module pgcs_monitor
	import pgcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [2:0] dsm_quant,
	input wire logic pfd_gain_enable,
	input wire logic csp_auto_reset_n,
	input wire logic general_output_one,
	input wire logic general_output_two,
	input wire logic general_output_three,
	input wire logic general_output_one_oe,
	input wire logic general_output_two_oe,
	input wire logic general_output_three_oe,
	input wire logic slip_direction,
	input wire logic cycle_slip_prevention,
	input wire logic pfd_ff_reset_n,
	input wire logic charge_pump_tristate
);
	logic [10:0] go_q;
	logic [5:0] cs_q;
	logic live_q;
	logic [2:0] pad;
	logic [2:0] oe;
	assign pad = {general_output_three, general_output_two, general_output_one};
	assign oe = {general_output_three_oe, general_output_two_oe,
		general_output_one_oe};
	// ==========================================================
	// shadow of the writable output and slip control fields
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			go_q <= 11'h000;
			cs_q <= 6'h20;
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
			if (reg_wr && reg_addr == 8'h1B)
				go_q <= reg_wdata[10:0];
			if (reg_wr && reg_addr == 8'h1C)
				cs_q <= reg_wdata[5:0];
		end
	end
	// ==========================================================
	// checks; outputs lag by one edge, so the first edge is skipped
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn || !live_q);
	a_read_answer: assert property (reg_rvalid == $past(reg_rd))
		else $error("read answer timing wrong");
	a_static_data: assert property ($past(go_q[3:0]) == 4'h0
		|-> pad == $past(go_q[6:4])) else $error("static data wrong");
	a_quant_out: assert property ($past(go_q[3:0]) == 4'hA
		|-> pad == $past(dsm_quant)) else $error("quantizer bits wrong");
	a_pad_enable: assert property (oe ==
		$past({3{go_q[7]}} & ~go_q[10:8])) else $error("pad enable wrong");
	a_slip_enable: assert property (cycle_slip_prevention ==
		$past(cs_q[3:0] != 4'h0 && cs_q[5] && pfd_gain_enable))
		else $error("slip enable wrong");
	a_pfd_reset_sel: assert property (pfd_ff_reset_n ==
		$past(cs_q[4] ? cs_q[5] : csp_auto_reset_n))
		else $error("detector reset wrong");
	a_pump_tristate: assert property (charge_pump_tristate ==
		$past(cs_q[4] && !cs_q[5])) else $error("pump tristate wrong");
	a_slip_dir: assert property (slip_direction == $past(cs_q[0]))
		else $error("slip direction wrong");
	c_quant: cover property ($past(go_q[3:0]) == 4'hA);
	c_forced: cover property (charge_pump_tristate);
	c_slip_on: cover property (cycle_slip_prevention);
endmodule

bind pgcs_regs pgcs_monitor u_mon (.*);

// [pll_gpo_csp_status_regs_tb.sv]
// self-checking bench for the synthesizer register group
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module pll_gpo_csp_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, reg_wr, reg_rd, reg_rvalid, pfd_gain_enable;
	logic csp_auto_reset_n, locked_in, sweep_active_in, slip_direction;
	logic cycle_slip_prevention, pfd_ff_reset_n, charge_pump_tristate;
	logic general_output_one, general_output_two, general_output_three;
	logic general_output_one_oe, general_output_two_oe;
	logic general_output_three_oe;
	logic [7:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata, c;
	logic [2:0] dsm_quant, modulator_overflow_in, e;
	logic [3:0] slip_step_count;
	logic signed [7:0] temp_celsius;
	int n_fail = 0;
	int compares = 0;
	logic [7:0] ra[9] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21,
		8'h22, 8'h40};
	logic [23:0] rv[9] = '{24'h0, 24'h20, 24'h0, 24'h0, 24'h0, 24'h20,
		24'h1F, 24'h0, 24'h0};
	int tl[11] = '{-50, -41, -40, -23, -22, 0, 42, 43, 82, 83, 127};
	pgcs_regs dut (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// bus tasks and expectations
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		// answer stands only in the cycle after the taking edge
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
		reg_rd = 1'b0;
	endtask
	function automatic logic [6:0] tcode(int t);
		int x;
		x = 2 * (t + 40);
		if (x < 0) return 7'h00;
		return (x / 35 > 7) ? 7'h07 : 7'(x / 35);
	endfunction
	task automatic tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
	// ==========================================================
	// main sequence
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, dsm_quant} = '0;
		{pfd_gain_enable, csp_auto_reset_n, locked_in} = '0;
		{sweep_active_in, modulator_overflow_in, temp_celsius} = '0;
		resetn = 1'b0;
		void'($urandom(32'h7B04));
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		for (int i = 2; i < 9; i++) begin
			if (i != 3) begin
				wr(ra[i], $urandom);
				rd(ra[i], rv[i]);
			end
		end
		// sweep pin high so the sweep select shows a non-zero bit
		sweep_active_in = 1'b1;
		for (int k = 0; k < 12; k++) begin
			c = $urandom;
			c[3:0] = (k % 3 == 0) ? 4'h0 : (k % 3 == 1) ? 4'hA : 4'h8;
			wr(8'h1B, c);
			dsm_quant = 3'($urandom);
			@(negedge clk);
			e = (k % 3 == 0) ? c[6:4] : (k % 3 == 1) ? dsm_quant : 3'h2;
			`CHK({general_output_three, general_output_two,
				general_output_one}, e)
			`CHK({general_output_three_oe, general_output_two_oe,
				general_output_one_oe}, {3{c[7]}} & ~c[10:8])
		end
		for (int k = 0; k < 12; k++) begin
			c = $urandom;
			{pfd_gain_enable, csp_auto_reset_n} = $urandom;
			wr(8'h1C, c);
			@(negedge clk);
			`CHK(slip_step_count, c[3:0])
			`CHK(slip_direction, c[0])
			`CHK(cycle_slip_prevention,
				c[3:0] != 4'h0 && c[5] && pfd_gain_enable)
			`CHK(pfd_ff_reset_n, c[4] ? c[5] : csp_auto_reset_n)
			`CHK(charge_pump_tristate, c[4] && !c[5])
			rd(8'h1C, {18'h0, c[5:0]});
		end
		for (int k = 0; k < 6; k++) begin
			{locked_in, sweep_active_in, modulator_overflow_in} = $urandom;
			repeat (5) @(negedge clk);
			rd(8'h1F, {18'h0, sweep_active_in, 1'b0, modulator_overflow_in,
				locked_in});
		end
		wr(8'h1E, 24'h1);
		foreach (tl[i]) begin
			temp_celsius = 8'(tl[i]);
			repeat (6) @(negedge clk);
			rd(8'h21, {17'h0, tcode(tl[i])});
		end
		tally_and_finish;
	end
endmodule
